// ---- logic/core_regs_pkg.sv ----
package core_regs_pkg;
  // ----------------------------------------
  // register indexes, byte address = 4*index
  // ----------------------------------------
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_INTERRUPT_ENABLES_FLAGS = 8'h0B;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PCL    = 8'h02;
  localparam logic [7:0] IDX_PROGRAM_COUNTER_HIGH_LATCH = 8'h0A;
  localparam logic [7:0] IDX_NVM    = 8'h0C;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ST_BANK = 5;
  localparam int ST_TO   = 4;
  localparam int ST_PD   = 3;
  localparam int ST_Z    = 2;
  localparam int ST_DC   = 1;
  localparam int ST_C    = 0;
  localparam int OP_PUD  = 7;
  localparam int OP_EDGE = 6;
  localparam int OP_TSRC = 5;
  localparam int OP_TSE  = 4;
  localparam int OP_PSA  = 3;
  localparam int IC_GIE  = 7;
  localparam int IC_NVM_WRITE_DONE_ENABLE = 6;
  localparam int IC_TIMER_OVERFLOW_FLAG = 2;
  localparam int IC_EXT_PIN_IRQ_FLAG = 1;
  localparam int IC_PORT_CHANGE_FLAG = 0;
  localparam int NV_FLAG = 4;
  // ----------------------------------------
  // reset values and constants
  // ----------------------------------------
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  OPTION_RST = 8'hFF;
  localparam logic [7:0]  ZERO8      = 8'h00;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_MOVE, OP_ADD, OP_SUB, OP_LOGIC, OP_ROL, OP_ROR,
    OP_WATCHDOG_CLEAR_INSTR, OP_SLEEP, OP_CALL, OP_GOTO, OP_RETURN, OP_RETURN_WITH_LITERAL,
    OP_RETURN_FROM_IRQ, OP_SKIP, OP_IRQ
  } op_type;
  typedef enum logic [2:0] {
    DEST_NONE, DEST_OTHER, DEST_STATUS, DEST_INTERRUPT_ENABLES_FLAGS, DEST_OPTION,
    DEST_PCL, DEST_PROGRAM_COUNTER_HIGH_LATCH, DEST_NVM
  } dest_type;
  typedef struct packed {
    op_type     op;
    logic [7:0] a;
    logic [7:0] b;
    dest_type   dest;
    logic [10:0] target;
  } exec_req_type;
  typedef struct packed {
    logic       use_pin;
    logic       falling;
    logic [3:0] timer_log2;
    logic [2:0] wdt_log2;
  } timer_cfg_type;
  typedef struct packed {
    logic [7:0] res;
    logic       dc;
    logic       c;
  } alu_out_type;
endpackage

// ---- logic/return_stack.sv ----
`timescale 1ns/10ps
module return_stack
  import core_regs_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
)(
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    ptr_reg;
  logic [PW-1:0]    last;

  assign last = ptr_reg - 1'b1;
  assign top  = mem_reg[last];

  // pointer wraps silently, ninth push lands on first slot
  always_ff @(posedge ref_clk)
    if (!rst_b)
      ptr_reg <= '0;
    else if (push)
      ptr_reg <= ptr_reg + 1'b1;
    else if (pop)
      ptr_reg <= last;

  always_ff @(posedge ref_clk)
    if (push)
      mem_reg[ptr_reg] <= push_data;

  a_push_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
    push |=> top == $past(push_data))
    else $error("stack top differs from last push");
endmodule // return_stack

// ---- logic/core_status_pc_stack_regs.sv ----
`timescale 1ns/10ps
module core_status_pc_stack_regs
  import core_regs_pkg::*;
#(
  parameter int AW = 12
)(
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          exec_valid,
  input  wire exec_req_type  exec_req,
  output logic               exec_stall,
  output logic [7:0]         alu_result,
  input  wire logic [6:0]    file_addr,
  output logic [7:0]         data_addr,
  output logic [12:0]        program_counter,
  output logic               irq_req,
  input  wire logic          external_reset_pin_b,
  input  wire logic          watchdog_timeout,
  input  wire logic          timer_overflow_evt,
  input  wire logic          nvm_write_busy,
  input  wire logic          external_irq_pin,
  input  wire logic [3:0]    port_upper_pins,
  input  wire logic [7:0]    port_latch,
  output logic [7:0]         pullup_en,
  output timer_cfg_type      timer_cfg
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]  status_reg;
  logic [7:0]  interrupt_enables_flags_reg;
  logic [7:0]  option_reg;
  logic [4:0]  program_counter_high_latch_reg;
  logic        nvm_flag_reg;
  logic        nvm_busy_reg;
  logic [12:0] pc_reg;
  logic [12:0] pc_next;
  logic        flush_reg;
  logic [7:0]  result_reg;
  logic [5:0]  s1_reg, s2_reg, s3_reg, pin_reg;
  logic [5:0]  pin_next;
  logic        bvalid_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [7:0]  rdata_reg;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic dest_type idx_dest(input logic [AW-1:0] addr);
    dest_type d;
    d = DEST_NONE;
    if (addr[1:0] == 2'b00 && addr[AW-1:10] == '0)
      unique case (addr[9:2])
        IDX_STATUS: d = DEST_STATUS;
        IDX_INTERRUPT_ENABLES_FLAGS: d = DEST_INTERRUPT_ENABLES_FLAGS;
        IDX_OPTION: d = DEST_OPTION;
        IDX_PCL:    d = DEST_PCL;
        IDX_PROGRAM_COUNTER_HIGH_LATCH: d = DEST_PROGRAM_COUNTER_HIGH_LATCH;
        IDX_NVM:    d = DEST_NVM;
        default:    d = DEST_NONE;
      endcase
    return d;
  endfunction

  // nibble and byte carries of a + b + cin
  function automatic alu_out_type add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    alu_out_type o;
    logic [4:0] lo;
    logic [8:0] full;
    lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    o.res = full[7:0];
    o.dc  = lo[4];
    o.c   = full[8];
    return o;
  endfunction

  // ----------------------------------------
  // pin synchroniser: reset pin, irq pin, port 7..4
  // ----------------------------------------
  always_ff @(posedge ref_clk)
    if (!rst_b)
    begin
      s1_reg  <= 6'h01;
      s2_reg  <= 6'h01;
      s3_reg  <= 6'h01;
      pin_reg <= 6'h01;
    end
    else
    begin
      s1_reg  <= {port_upper_pins, external_irq_pin, external_reset_pin_b};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= pin_next;
    end

  always_comb
    for (int i = 0; i < 6; i++)
      pin_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : pin_reg[i];

  logic soft_rst, irq_edge, port_change, nvm_done;
  assign soft_rst    = !pin_reg[0] || watchdog_timeout;
  assign irq_edge    = (pin_next[1] != pin_reg[1]) &&
                       (pin_next[1] == option_reg[OP_EDGE]);
  assign port_change = pin_next[5:2] != pin_reg[5:2];
  assign nvm_done    = nvm_busy_reg && !nvm_write_busy;

  // ----------------------------------------
  // instruction side
  // ----------------------------------------
  op_type      op;
  logic        ex_go, aff_z, aff_dcc, aff_c, pc_jump;
  alu_out_type sum;
  logic [7:0]  res;
  logic        c_new;

  assign op      = exec_req.op;
  assign ex_go   = exec_valid && !flush_reg && !soft_rst;
  assign aff_z   = op inside {OP_ADD, OP_SUB, OP_LOGIC};
  assign aff_dcc = op inside {OP_ADD, OP_SUB};
  assign aff_c   = op inside {OP_ADD, OP_SUB, OP_ROL, OP_ROR};
  assign pc_jump = op inside {OP_CALL, OP_GOTO, OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_IRQ,
                              OP_SKIP, OP_IRQ} || exec_req.dest == DEST_PCL;

  always_comb
  begin
    sum   = add8(exec_req.a, exec_req.b, 1'b0);
    res   = exec_req.a;
    c_new = sum.c;
    unique case (op)
      OP_ADD: res = sum.res;
      OP_SUB:
      begin
        sum   = add8(exec_req.a, ~exec_req.b, 1'b1);
        res   = sum.res;
        c_new = sum.c;
      end
      OP_ROL:
      begin
        res   = {exec_req.a[6:0], status_reg[ST_C]};
        c_new = exec_req.a[7];
      end
      OP_ROR:
      begin
        res   = {status_reg[ST_C], exec_req.a[7:1]};
        c_new = exec_req.a[0];
      end
      default: res = exec_req.a;
    endcase
  end

  // ----------------------------------------
  // unified register write port, datapath first
  // ----------------------------------------
  logic     axi_wr, ex_wr, wr;
  dest_type wr_dest;
  logic [7:0] wr_data;
  assign ex_wr  = ex_go && exec_req.dest != DEST_NONE;
  assign axi_wr = s_axi_awvalid && s_axi_wvalid && !bvalid_reg && !ex_wr;
  assign wr      = ex_wr || (axi_wr && s_axi_wstrb[0]);
  assign wr_dest = ex_wr ? exec_req.dest : idx_dest(s_axi_awaddr);
  assign wr_data = ex_wr ? res : s_axi_wdata[7:0];

  // ----------------------------------------
  // status
  // ----------------------------------------
  always_ff @(posedge ref_clk)
    if (!rst_b)
      status_reg <= STATUS_RST;
    else
    begin
      if (wr && wr_dest == DEST_STATUS)
      begin
        status_reg[7:ST_BANK] <= wr_data[7:ST_BANK];
        if (!(ex_go && aff_z))
          status_reg[ST_Z] <= wr_data[ST_Z];
        if (!(ex_go && aff_dcc))
          status_reg[ST_DC] <= wr_data[ST_DC];
        if (!(ex_go && aff_c))
          status_reg[ST_C] <= wr_data[ST_C];
      end
      if (ex_go && aff_z)
        status_reg[ST_Z] <= res == ZERO8;
      if (ex_go && aff_dcc)
        status_reg[ST_DC] <= sum.dc;
      if (ex_go && aff_c)
        status_reg[ST_C] <= c_new;
      if (ex_go && op == OP_WATCHDOG_CLEAR_INSTR)
      begin
        status_reg[ST_TO] <= 1'b1;
        status_reg[ST_PD] <= 1'b1;
      end
      if (ex_go && op == OP_SLEEP)
      begin
        status_reg[ST_TO] <= 1'b1;
        status_reg[ST_PD] <= 1'b0;
      end
      if (watchdog_timeout)
        status_reg[ST_TO] <= 1'b0;
      if (soft_rst)
        status_reg[7:ST_BANK] <= '0;
    end

  assign data_addr = {status_reg[ST_BANK], file_addr};

  // ----------------------------------------
  // option and program_counter_high_latch
  // ----------------------------------------
  always_ff @(posedge ref_clk)
    if (!rst_b || soft_rst)
      option_reg <= OPTION_RST;
    else if (wr && wr_dest == DEST_OPTION)
      option_reg <= wr_data;

  always_ff @(posedge ref_clk)
    if (!rst_b || soft_rst)
      program_counter_high_latch_reg <= '0;
    else if (wr && wr_dest == DEST_PROGRAM_COUNTER_HIGH_LATCH)
      program_counter_high_latch_reg <= wr_data[4:0];

  assign pullup_en = option_reg[OP_PUD] ? ZERO8 : port_latch;
  assign timer_cfg.use_pin = option_reg[OP_TSRC];
  assign timer_cfg.falling = option_reg[OP_TSE];
  assign timer_cfg.timer_log2 = option_reg[OP_PSA] ? 4'h0 :
                                {1'b0, option_reg[2:0]} + 4'h1;
  assign timer_cfg.wdt_log2 = option_reg[OP_PSA] ? option_reg[2:0] : 3'h0;

  // ----------------------------------------
  // interrupt enables and flags, set beats clear
  // ----------------------------------------
  always_ff @(posedge ref_clk)
    if (!rst_b)
      interrupt_enables_flags_reg <= ZERO8;
    else if (soft_rst)
      interrupt_enables_flags_reg[7:1] <= '0;
    else
    begin
      if (wr && wr_dest == DEST_INTERRUPT_ENABLES_FLAGS)
        interrupt_enables_flags_reg <= wr_data;
      if (ex_go && op == OP_IRQ)
        interrupt_enables_flags_reg[IC_GIE] <= 1'b0;
      if (ex_go && op == OP_RETURN_FROM_IRQ)
        interrupt_enables_flags_reg[IC_GIE] <= 1'b1;
      if (timer_overflow_evt)
        interrupt_enables_flags_reg[IC_TIMER_OVERFLOW_FLAG] <= 1'b1;
      if (irq_edge)
        interrupt_enables_flags_reg[IC_EXT_PIN_IRQ_FLAG] <= 1'b1;
      if (port_change)
        interrupt_enables_flags_reg[IC_PORT_CHANGE_FLAG] <= 1'b1;
    end

  always_ff @(posedge ref_clk)
    if (!rst_b)
    begin
      nvm_flag_reg <= 1'b0;
      nvm_busy_reg <= 1'b0;
    end
    else
    begin
      nvm_busy_reg <= nvm_write_busy;
      if (wr && wr_dest == DEST_NVM)
        nvm_flag_reg <= wr_data[NV_FLAG];
      if (nvm_done)
        nvm_flag_reg <= 1'b1;
    end

  assign irq_req = interrupt_enables_flags_reg[IC_GIE] &&
    |({nvm_flag_reg, interrupt_enables_flags_reg[IC_TIMER_OVERFLOW_FLAG:IC_PORT_CHANGE_FLAG]} & interrupt_enables_flags_reg[IC_NVM_WRITE_DONE_ENABLE:3]);

  // ----------------------------------------
  // program counter, stack, two-cycle ops
  // ----------------------------------------
  logic [12:0] stack_top;
  logic        push, pop;
  assign push = ex_go && op inside {OP_CALL, OP_IRQ};
  assign pop  = ex_go && op inside {OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_IRQ};

  return_stack #(.DEPTH(8), .WIDTH(13)) u_stack (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .push      (push),
    .pop       (pop),
    .push_data (pc_reg + 13'h1),
    .top       (stack_top)
  );

  always_comb
  begin
    pc_next = pc_reg;
    if (ex_go)
    begin
      unique case (op)
        OP_CALL, OP_GOTO: pc_next = {program_counter_high_latch_reg[4:3], exec_req.target};
        OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_IRQ: pc_next = stack_top;
        OP_IRQ:  pc_next = IRQ_VECTOR;
        OP_SKIP: pc_next = pc_reg + 13'h2;
        default: pc_next = pc_reg + 13'h1;
      endcase
    end
    if (wr && wr_dest == DEST_PCL)
      pc_next = {program_counter_high_latch_reg, wr_data};
  end

  always_ff @(posedge ref_clk)
    if (!rst_b || soft_rst)
      pc_reg <= '0;
    else
      pc_reg <= pc_next;

  always_ff @(posedge ref_clk)
    if (!rst_b)
      flush_reg <= 1'b0;
    else
      flush_reg <= ex_go && pc_jump;

  always_ff @(posedge ref_clk)
    if (!rst_b)
      result_reg <= ZERO8;
    else if (ex_go)
      result_reg <= res;

  assign exec_stall      = flush_reg;
  assign alu_result      = result_reg;
  assign program_counter = pc_reg;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  assign s_axi_awready = axi_wr;
  assign s_axi_wready  = axi_wr;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};

  always_ff @(posedge ref_clk)
    if (!rst_b)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (axi_wr)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= idx_dest(s_axi_awaddr) == DEST_NONE ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;

  always_ff @(posedge ref_clk)
    if (!rst_b)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= ZERO8;
    end
    else if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      unique case (idx_dest(s_axi_araddr))
        DEST_STATUS: rdata_reg <= status_reg;
        DEST_INTERRUPT_ENABLES_FLAGS: rdata_reg <= interrupt_enables_flags_reg;
        DEST_OPTION: rdata_reg <= option_reg;
        DEST_PCL:    rdata_reg <= pc_reg[7:0];
        DEST_PROGRAM_COUNTER_HIGH_LATCH: rdata_reg <= {3'h0, program_counter_high_latch_reg};
        DEST_NVM:    rdata_reg <= {3'h0, nvm_flag_reg, 4'h0};
        default:
        begin
          rdata_reg <= ZERO8;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_jump_go;
    ex_go && op == OP_GOTO;
  endsequence
  sequence s_one_dead_cycle;
    flush_reg && !ex_go ##1 !flush_reg;
  endsequence

  a_branch_two_cycles: assert property (s_jump_go |=> s_one_dead_cycle)
    else $error("branch did not take exactly two cycles");
  a_watchdog_clear_instr_flags: assert property (ex_go && op == OP_WATCHDOG_CLEAR_INSTR && !watchdog_timeout
    |=> status_reg[ST_TO] && status_reg[ST_PD])
    else $error("clear-watchdog did not set both flags");
  a_sleep_flags: assert property (ex_go && op == OP_SLEEP && !watchdog_timeout
    |=> status_reg[ST_TO] && !status_reg[ST_PD])
    else $error("sleep did not set the flags");
  a_timeout_clears: assert property (watchdog_timeout |=> !status_reg[ST_TO])
    else $error("time-out left flag set");
  a_status_ro_bits: assert property (axi_wr && wr_dest == DEST_STATUS
    && !watchdog_timeout |=> $stable(status_reg[ST_TO:ST_PD]))
    else $error("software changed read-only flags");
  a_zero_logic: assert property (ex_go && op == OP_LOGIC && exec_req.a == ZERO8
    |=> status_reg[ST_Z])
    else $error("zero result left zero flag clear");
  a_flag_sticky: assert property (timer_overflow_evt && !soft_rst
    |=> interrupt_enables_flags_reg[IC_TIMER_OVERFLOW_FLAG] [*2] or ##1 (wr && wr_dest == DEST_INTERRUPT_ENABLES_FLAGS))
    else $error("overflow flag lost");
  a_gie_blocks: assert property (!interrupt_enables_flags_reg[IC_GIE] |-> !irq_req)
    else $error("request raised with global enable off");
  a_latch_kept: assert property ((push || pop) && !(wr && wr_dest == DEST_PROGRAM_COUNTER_HIGH_LATCH)
    |=> $stable(program_counter_high_latch_reg))
    else $error("stack op changed latch");
endmodule // core_status_pc_stack_regs

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb
  import core_regs_pkg::*;
;
  // ----
  // signals
  // ----
  logic          ref_clk = 1'b0;
  logic          rst_b = 1'b0;
  logic [11:0]   s_axi_awaddr = '0;
  logic [11:0]   s_axi_araddr = '0;
  logic [31:0]   s_axi_wdata = '0;
  logic [3:0]    s_axi_wstrb = 4'hF;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, exec_valid = 1'b0;
  exec_req_type  exec_req = '0;
  logic [6:0]    file_addr = 7'h15;
  logic          external_reset_pin_b = 1'b1, watchdog_timeout = 1'b0;
  logic          timer_overflow_evt = 1'b0, nvm_write_busy = 1'b0, external_irq_pin = 1'b0;
  logic [3:0]    port_upper_pins = 4'h0;
  logic [7:0]    port_latch = 8'hA5;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic          exec_stall, irq_req;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0]   s_axi_rdata, rd;
  logic [7:0]    alu_result, data_addr, pullup_en;
  logic [12:0]   program_counter;
  timer_cfg_type timer_cfg;
  int            errors = 0;
  int            checks = 0;

  core_status_pc_stack_regs #(.AW(12)) dut (.*);

  always #5 ref_clk = ~ref_clk;

  // ----
  // tasks
  // ----
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // bounded wait, sampled mid-cycle where handshakes are settled
  task automatic wait_hi(input int w);
    logic [3:0] v;
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      v = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};
      n++;
    end
    while (v[w] !== 1'b1 && n < 50);
    if (v[w] !== 1'b1)
    begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    tick(1);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wait_hi(0);
    tick(1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wait_hi(1);
    rsp = s_axi_bresp;
    tick(1);
    s_axi_bready <= 1'b0;
    chk(rsp, er);
  endtask

  task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
    tick(1);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(2);
    tick(1);
    s_axi_arvalid <= 1'b0;
    wait_hi(3);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    tick(1);
    s_axi_rready <= 1'b0;
    chk(rd, {24'h0, e});
  endtask

  task automatic ex(input op_type o, input logic [7:0] ea, input logic [7:0] eb,
                    input dest_type d, input logic [10:0] t, input logic es);
    tick(1);
    exec_valid <= 1'b1;
    exec_req <= '{op: o, a: ea, b: eb, dest: d, target: t};
    tick(1);
    exec_valid <= 1'b0;
    #1;
    chk(exec_stall, es);
  endtask

  task automatic br(input op_type o, input logic [10:0] t);
    ex(o, 8'h00, 8'h00, DEST_NONE, t, 1'b1);
  endtask

  task automatic alu(input op_type o, input logic [7:0] ea, input logic [7:0] eb,
                     input logic [7:0] er, input logic [2:0] fl);
    ex(o, ea, eb, DEST_OTHER, 11'h0, 1'b0);
    chk(alu_result, er);
    rd_chk(IDX_STATUS, {5'h03, fl});
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rd_chk(IDX_STATUS, STATUS_RST);
    rd_chk(IDX_OPTION, OPTION_RST);
    rd_chk(IDX_INTERRUPT_ENABLES_FLAGS, ZERO8);
    rd_chk(IDX_PROGRAM_COUNTER_HIGH_LATCH, ZERO8);
    chk(pullup_en, 8'h00);
    rd_chk(8'hFF, 8'h00);
    chk(rsp, RESP_SLVERR);
    wr(8'hFF, 8'h55, RESP_SLVERR);
  endtask

  task automatic t_status();
    wr(IDX_STATUS, 8'hE7);
    rd_chk(IDX_STATUS, 8'hFF);
    chk(data_addr, {1'b1, file_addr});
    wr(IDX_STATUS, 8'h00);
    rd_chk(IDX_STATUS, 8'h18);
    chk(data_addr, {1'b0, file_addr});
    alu(OP_ADD, 8'h0F, 8'h01, 8'h10, 3'b010);
    alu(OP_ADD, 8'hFF, 8'h01, 8'h00, 3'b111);
    alu(OP_LOGIC, 8'h00, 8'h00, 8'h00, 3'b111);
    alu(OP_SUB, 8'h05, 8'h05, 8'h00, 3'b111);
    alu(OP_SUB, 8'h00, 8'h01, 8'hFF, 3'b000);
    ex(OP_ROL, 8'h80, 8'h00, DEST_OTHER, 11'h0, 1'b0);
    rd_chk(IDX_STATUS, 8'h19);
    ex(OP_ROR, 8'h00, 8'h00, DEST_OTHER, 11'h0, 1'b0);
    rd_chk(IDX_STATUS, 8'h18);
    wr(IDX_STATUS, 8'h38);
    ex(OP_SUB, 8'h03, 8'h03, DEST_STATUS, 11'h0, 1'b0);
    rd_chk(IDX_STATUS, 8'h1F);
    ex(OP_ADD, 8'hE0, 8'h00, DEST_STATUS, 11'h0, 1'b0);
    rd_chk(IDX_STATUS, 8'hF8);
  endtask

  task automatic t_power();
    ex(OP_SLEEP, 8'h00, 8'h00, DEST_NONE, 11'h0, 1'b0);
    rd_chk(IDX_STATUS, 8'hF0);
    ex(OP_WATCHDOG_CLEAR_INSTR, 8'h00, 8'h00, DEST_NONE, 11'h0, 1'b0);
    rd_chk(IDX_STATUS, 8'hF8);
    watchdog_timeout <= 1'b1;
    tick(1);
    watchdog_timeout <= 1'b0;
    rd_chk(IDX_STATUS, 8'h08);
    ex(OP_SLEEP, 8'h00, 8'h00, DEST_NONE, 11'h0, 1'b0);
    rd_chk(IDX_STATUS, 8'h10);
    external_reset_pin_b <= 1'b0;
    tick(6);
    external_reset_pin_b <= 1'b1;
    tick(6);
    rd_chk(IDX_STATUS, 8'h10);
  endtask

  task automatic t_irq();
    timer_overflow_evt <= 1'b1;
    tick(1);
    timer_overflow_evt <= 1'b0;
    rd_chk(IDX_INTERRUPT_ENABLES_FLAGS, 8'h04);
    wr(IDX_INTERRUPT_ENABLES_FLAGS, 8'hA4);
    chk(irq_req, 1'b1);
    wr(IDX_INTERRUPT_ENABLES_FLAGS, 8'h94);
    chk(irq_req, 1'b0);
    external_irq_pin <= 1'b1;
    tick(6);
    rd_chk(IDX_INTERRUPT_ENABLES_FLAGS, 8'h96);
    chk(irq_req, 1'b1);
    wr(IDX_INTERRUPT_ENABLES_FLAGS, 8'h00);
    wr(IDX_OPTION, 8'h00);
    external_irq_pin <= 1'b0;
    port_upper_pins <= 4'h8;
    tick(6);
    rd_chk(IDX_INTERRUPT_ENABLES_FLAGS, 8'h03);
    nvm_write_busy <= 1'b1;
    tick(2);
    nvm_write_busy <= 1'b0;
    tick(2);
    rd_chk(IDX_NVM, 8'h10);
    wr(IDX_INTERRUPT_ENABLES_FLAGS, 8'hC0);
    chk(irq_req, 1'b1);
  endtask

  task automatic t_opt();
    wr(IDX_OPTION, 8'h00);
    chk(timer_cfg, 9'h008);
    chk(pullup_en, port_latch);
    wr(IDX_OPTION, 8'h7B);
    chk(timer_cfg, 9'h183);
    wr(IDX_OPTION, 8'h87);
    chk(timer_cfg, 9'h040);
    chk(pullup_en, 8'h00);
    rd_chk(IDX_OPTION, 8'h87);
  endtask

  task automatic t_pc();
    int i;
    wr(IDX_PROGRAM_COUNTER_HIGH_LATCH, 8'h1F);
    br(OP_GOTO, 11'h123);
    chk(program_counter, 13'h1923);
    ex(OP_MOVE, 8'h55, 8'h00, DEST_PCL, 11'h0, 1'b1);
    chk(program_counter, 13'h1F55);
    rd_chk(IDX_PCL, 8'h55);
    rd_chk(IDX_PROGRAM_COUNTER_HIGH_LATCH, 8'h1F);
    wr(IDX_PROGRAM_COUNTER_HIGH_LATCH, 8'h00);
    br(OP_GOTO, 11'h000);
    for (i = 1; i <= 9; i++)
      br(OP_CALL, 11'(i * 16));
    for (i = 1; i <= 9; i++)
    begin
      br(OP_RETURN, 11'h0);
      chk(program_counter, (i < 9) ? 13'((9 - i) * 16 + 1) : 13'h081);
    end
    br(OP_IRQ, 11'h0);
    chk(program_counter, IRQ_VECTOR);
    br(OP_RETURN_FROM_IRQ, 11'h0);
    chk(program_counter, 13'h082);
    br(OP_SKIP, 11'h0);
    chk(program_counter, 13'h084);
    rd_chk(IDX_PROGRAM_COUNTER_HIGH_LATCH, 8'h00);
  endtask

  initial
  begin
    tick(6);
    rst_b <= 1'b1;
    t_reset();
    t_status();
    t_power();
    t_irq();
    t_opt();
    t_pc();
    wrap_up();
  end

  initial
  begin
    tick(20000);
    errors++;
    wrap_up();
  end
endmodule // tb
